//--- rtl/pur_irq1_sync.sv
// Purpose: Synchronise the external interrupt 1 pin and detect its edge
// Assumes: Pin is asynchronous to clk_i
// Notes:   A change counts once the second and third stages agree
`timescale 1ns/10ps
module pur_irq1_sync #(
    parameter int unsigned STAGES = pur_pkg::SYNC_STAGES
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ext_irq1_pin_i,
    pur_edge_if.detector edge_if
);
    initial begin
        if (STAGES != 3) begin
            $error("pur_irq1_sync supports exactly three stages");
        end
    end

    typedef struct packed {
        logic [2:0] sync;
        logic       level;
        logic       event_p;
    } pur_sync_state_t;

    pur_sync_state_t st_r;
    pur_sync_state_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        // First stage feeds only the second
        st_nxt.sync = {st_r.sync[1], st_r.sync[0], ext_irq1_pin_i};
        if (st_r.sync[1] == st_r.sync[2]) begin
            st_nxt.level = st_r.sync[2];
        end
        // Only the selected direction raises the event
        st_nxt.event_p = (st_nxt.level != st_r.level) &&
                         (st_nxt.level == edge_if.edge_sel);
    end

    // Idle high so a pulled-up pin gives no event after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.sync    <= pur_pkg::SYNC_RST;
            st_r.level   <= 1'b1;
            st_r.event_p <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign edge_if.event_p = st_r.event_p;
endmodule

//--- rtl/pur_top.sv
// Purpose: Pull-up control and output routing for ports A, B and D
// Assumes: Classic Wishbone slave, 32-bit data, 8-bit registers in low lane
// Notes:   Timers, PWM engine and port data registers live elsewhere
//
// Functional notes
// - A pull-up disable bit of 0 enables that pin's pull-up, 1 disables it.
// - A pin whose output data bit is 0 never has its pull-up on.
// - A pin set to push-pull output never has its pull-up on.
// - A pin serving crystal, PWM, toggle, clock or buzzer has no pull-up.
// - PWM enable routes the PWM waveform to port A pin 0, else normal use.
// - Clock output enable drives the half-rate clock on port D pin 6.
// - Timer0 toggle enable drives an overflow toggle on port A pin 5.
// - Timer1 toggle enable drives an overflow toggle on port D pin 0.
// - Timer1 clock select picks half rate at 0 and full rate at 1.
// - Interrupt 1 edge select picks falling edge at 0, rising at 1.
// - Push-pull select 1 gives CMOS output, 0 open-drain or input.
`timescale 1ns/10ps
module pur_top #(
    parameter int unsigned ADR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADR_W-1:0]  adr_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    input  wire logic              we_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic              stb_i,
    input  wire logic              cyc_i,
    output logic                   ack_o,
    input  wire logic [7:0]        porta_output_data_i,
    input  wire logic [7:0]        portb_output_data_i,
    input  wire logic [7:0]        portd_output_data_i,
    input  wire logic [7:0]        porta_pushpull_select_i,
    input  wire logic [7:0]        portb_pushpull_select_i,
    input  wire logic [7:0]        portd_pushpull_select_i,
    input  wire logic [7:0]        porta_alt_func_i,
    input  wire logic [7:0]        portb_alt_func_i,
    input  wire logic [7:0]        portd_alt_func_i,
    input  wire logic              pwm_wave_i,
    input  wire logic              timer0_ovf_i,
    input  wire logic              timer1_ovf_i,
    input  wire logic              ext_irq1_pin_i,
    output logic      [7:0]        porta_pullup_o,
    output logic      [7:0]        portb_pullup_o,
    output logic      [7:0]        portd_pullup_o,
    output logic      [7:0]        porta_pushpull_o,
    output logic      [7:0]        portb_pushpull_o,
    output logic      [7:0]        portd_pushpull_o,
    output logic                   porta_pin0_sel_o,
    output logic                   porta_pin0_out_o,
    output logic                   porta_pin5_sel_o,
    output logic                   porta_pin5_out_o,
    output logic                   portd_pin6_sel_o,
    output logic                   portd_pin6_out_o,
    output logic                   portd_pin0_sel_o,
    output logic                   portd_pin0_out_o,
    output logic      [1:0]        pwm_clock_divider_o,
    output logic                   timer1_clk_tick_o,
    output logic                   ext_irq1_event_o,
    output logic                   irq_o
);
    initial begin
        if (ADR_W < 8) begin
            $error("pur_top needs at least 8 address bits");
        end
    end

    typedef struct packed {
        logic [7:0] pa_pud;
        logic [7:0] pb_pud;
        logic [7:0] pd_pud;
        logic [7:0] route;
        logic [2:0] irq_sts;
        logic [2:0] irq_en;
        logic       ack;
        logic [7:0] rdata;
        logic [7:0] pa_pu;
        logic [7:0] pb_pu;
        logic [7:0] pd_pu;
        logic [7:0] pa_pp;
        logic [7:0] pb_pp;
        logic [7:0] pd_pp;
        logic       instr_clk;
        logic       t1_tick;
        logic       t0_tog;
        logic       t1_tog;
        logic       pa0_sel;
        logic       pa0_val;
        logic       pa5_sel;
        logic       pa5_val;
        logic       pd6_sel;
        logic       pd6_val;
        logic       pd0_sel;
        logic       pd0_val;
        logic       irq1_ev;
        logic       irq;
    } pur_state_t;

    pur_state_t st_r;
    pur_state_t st_nxt;

    pur_edge_if edge_if ();

    pur_irq1_sync u_irq1_sync (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .ext_irq1_pin_i (ext_irq1_pin_i),
        .edge_if        (edge_if)
    );

    assign edge_if.edge_sel = st_r.route[pur_pkg::RT_IRQ1_EDGE];

    // Pull-up only when enabled, data high, not push-pull, no alt use
    function automatic logic [7:0] pullup_calc(
        input logic [7:0] pud,
        input logic [7:0] data,
        input logic [7:0] pp,
        input logic [7:0] busy
    );
        pullup_calc = ~pud & data & ~pp & ~busy;
    endfunction

    function automatic logic is_reg(
        input logic [ADR_W-1:0] adr,
        input logic [5:0]       idx
    );
        is_reg = (adr[7:pur_pkg::IDX_SHIFT] == idx) &&
                 (adr[pur_pkg::IDX_SHIFT-1:0] == 2'b00);
    endfunction

    logic       req;
    logic       wr_lo;
    logic [7:0] wd;
    logic [7:0] pa_busy;
    logic [7:0] pd_busy;
    logic [2:0] irq_ev;
    logic [2:0] irq_clr;

    always_comb begin
        req     = cyc_i && stb_i && !st_r.ack;
        wr_lo   = req && we_i && sel_i[0];
        wd      = dat_i[7:0];
        irq_clr = 3'h0;
        st_nxt  = st_r;

        st_nxt.ack   = req;
        st_nxt.rdata = 8'h00;

        // Control registers keep their value until written
        if (wr_lo) begin
            if (is_reg(adr_i, pur_pkg::IDX_PA_PUD)) begin
                st_nxt.pa_pud = wd;
            end
            if (is_reg(adr_i, pur_pkg::IDX_PB_PUD)) begin
                st_nxt.pb_pud = wd;
            end
            if (is_reg(adr_i, pur_pkg::IDX_PD_PUD)) begin
                st_nxt.pd_pud = wd;
            end
            if (is_reg(adr_i, pur_pkg::IDX_ROUTE)) begin
                st_nxt.route = wd;
            end
            if (is_reg(adr_i, pur_pkg::IDX_IRQ_CLR)) begin
                irq_clr = wd[pur_pkg::IRQ_W-1:0];
            end
            if (is_reg(adr_i, pur_pkg::IDX_IRQ_EN)) begin
                st_nxt.irq_en = wd[pur_pkg::IRQ_W-1:0];
            end
        end

        // Write-only registers read back as zero
        if (req && !we_i) begin
            if (is_reg(adr_i, pur_pkg::IDX_IRQ_STS)) begin
                st_nxt.rdata = {5'h00, st_r.irq_sts};
            end
            if (is_reg(adr_i, pur_pkg::IDX_IRQ_EN)) begin
                st_nxt.rdata = {5'h00, st_r.irq_en};
            end
        end

        // Half-rate instruction clock runs free
        st_nxt.instr_clk = !st_r.instr_clk;

        // Full rate ticks every cycle, half rate every other
        st_nxt.t1_tick = st_r.route[pur_pkg::RT_T1_CLKSEL] ? 1'b1
                                                           : st_nxt.instr_clk;

        // Toggle only while enabled, from a low reset
        if (timer0_ovf_i && st_r.route[pur_pkg::RT_T0_EN]) begin
            st_nxt.t0_tog = !st_r.t0_tog;
        end
        if (timer1_ovf_i && st_r.route[pur_pkg::RT_T1_EN]) begin
            st_nxt.t1_tog = !st_r.t1_tog;
        end

        st_nxt.pa0_sel = st_r.route[pur_pkg::RT_PWM_EN];
        st_nxt.pa0_val = st_r.route[pur_pkg::RT_PWM_EN] && pwm_wave_i;
        st_nxt.pa5_sel = st_r.route[pur_pkg::RT_T0_EN];
        st_nxt.pa5_val = st_r.route[pur_pkg::RT_T0_EN] && st_nxt.t0_tog;
        st_nxt.pd0_sel = st_r.route[pur_pkg::RT_T1_EN];
        st_nxt.pd0_val = st_r.route[pur_pkg::RT_T1_EN] && st_nxt.t1_tog;
        st_nxt.pd6_sel = st_r.route[pur_pkg::RT_CLK_EN];
        st_nxt.pd6_val = st_r.route[pur_pkg::RT_CLK_EN] && st_nxt.instr_clk;

        // Pins taken by routed functions lose their pull-up
        pa_busy = porta_alt_func_i;
        pd_busy = portd_alt_func_i;
        pa_busy[pur_pkg::PIN_PWM] = pa_busy[pur_pkg::PIN_PWM] |
                                    st_r.route[pur_pkg::RT_PWM_EN];
        pa_busy[pur_pkg::PIN_T0]  = pa_busy[pur_pkg::PIN_T0] |
                                    st_r.route[pur_pkg::RT_T0_EN];
        pd_busy[pur_pkg::PIN_CLK] = pd_busy[pur_pkg::PIN_CLK] |
                                    st_r.route[pur_pkg::RT_CLK_EN];
        pd_busy[pur_pkg::PIN_T1]  = pd_busy[pur_pkg::PIN_T1] |
                                    st_r.route[pur_pkg::RT_T1_EN];

        // Pull-up gating by disable, data and mode
        st_nxt.pa_pu = pullup_calc(st_r.pa_pud, porta_output_data_i,
                                   porta_pushpull_select_i, pa_busy);
        st_nxt.pb_pu = pullup_calc(st_r.pb_pud, portb_output_data_i,
                                   portb_pushpull_select_i, portb_alt_func_i);
        st_nxt.pd_pu = pullup_calc(st_r.pd_pud, portd_output_data_i,
                                   portd_pushpull_select_i, pd_busy);

        // Output mode passed to the pad drivers
        st_nxt.pa_pp = porta_pushpull_select_i;
        st_nxt.pb_pp = portb_pushpull_select_i;
        st_nxt.pd_pp = portd_pushpull_select_i;

        st_nxt.irq1_ev = edge_if.event_p;

        // New events win over a clear in the same cycle
        irq_ev = 3'h0;
        irq_ev[pur_pkg::IRQ_T0]   = timer0_ovf_i;
        irq_ev[pur_pkg::IRQ_T1]   = timer1_ovf_i;
        irq_ev[pur_pkg::IRQ_EXT1] = edge_if.event_p;
        st_nxt.irq_sts = (st_r.irq_sts & ~irq_clr) | irq_ev;
        st_nxt.irq     = |(st_nxt.irq_sts & st_nxt.irq_en);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r        <= '0;
            st_r.pa_pud <= pur_pkg::RST_PA_PUD;
            st_r.pb_pud <= pur_pkg::RST_PB_PUD;
            st_r.pd_pud <= pur_pkg::RST_PD_PUD;
            st_r.route  <= pur_pkg::RST_ROUTE;
            st_r.irq_en <= pur_pkg::RST_IRQ_EN;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dat_o               = {24'h000000, st_r.rdata};
    assign ack_o               = st_r.ack;
    assign porta_pullup_o      = st_r.pa_pu;
    assign portb_pullup_o      = st_r.pb_pu;
    assign portd_pullup_o      = st_r.pd_pu;
    assign porta_pushpull_o    = st_r.pa_pp;
    assign portb_pushpull_o    = st_r.pb_pp;
    assign portd_pushpull_o    = st_r.pd_pp;
    assign porta_pin0_sel_o    = st_r.pa0_sel;
    assign porta_pin0_out_o    = st_r.pa0_val;
    assign porta_pin5_sel_o    = st_r.pa5_sel;
    assign porta_pin5_out_o    = st_r.pa5_val;
    assign portd_pin6_sel_o    = st_r.pd6_sel;
    assign portd_pin6_out_o    = st_r.pd6_val;
    assign portd_pin0_sel_o    = st_r.pd0_sel;
    assign portd_pin0_out_o    = st_r.pd0_val;
    // Divider is only passed on; nonzero values upset the PWM engine
    assign pwm_clock_divider_o = st_r.route[pur_pkg::RT_PWM_DIV_H:
                                            pur_pkg::RT_PWM_DIV_L];
    assign timer1_clk_tick_o   = st_r.t1_tick;
    assign ext_irq1_event_o    = st_r.irq1_ev;
    assign irq_o               = st_r.irq;
endmodule

//--- shared/pur_edge_if.sv
// Purpose: Carries edge select and detected event for the irq1 pin
// Assumes: Single clock domain
// Notes:   Detector drives the event, user drives edge select
`timescale 1ns/10ps
interface pur_edge_if;
    logic edge_sel;
    logic event_p;

    modport detector (
        input  edge_sel,
        output event_p
    );
    modport user (
        output edge_sel,
        input  event_p
    );
endinterface

//--- shared/pur_pkg.sv
// Purpose: Shared constants for the pull-up and output routing block
// Assumes: 8-bit registers on a 32-bit Wishbone word, one register a word
// Notes:   Byte address of a register is its index shifted by IDX_SHIFT
package pur_pkg;

    localparam int unsigned REG_W     = 8;
    localparam int unsigned IDX_SHIFT = 2;

    // Register indices
    localparam logic [5:0] IDX_PA_PUD  = 6'h08;
    localparam logic [5:0] IDX_PB_PUD  = 6'h09;
    localparam logic [5:0] IDX_PD_PUD  = 6'h0A;
    localparam logic [5:0] IDX_ROUTE   = 6'h0B;
    localparam logic [5:0] IDX_IRQ_STS = 6'h0C;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h0D;
    localparam logic [5:0] IDX_IRQ_EN  = 6'h0E;

    // Reset values
    localparam logic [7:0] RST_PA_PUD = 8'h7F;
    localparam logic [7:0] RST_PB_PUD = 8'h3F;
    localparam logic [7:0] RST_PD_PUD = 8'hFF;
    localparam logic [7:0] RST_ROUTE  = 8'h00;
    localparam logic [2:0] RST_IRQ_EN = 3'h0;

    // Field positions of output_routing_control
    localparam int unsigned RT_PWM_EN    = 7;
    localparam int unsigned RT_PWM_DIV_H = 6;
    localparam int unsigned RT_PWM_DIV_L = 5;
    localparam int unsigned RT_CLK_EN    = 4;
    localparam int unsigned RT_T0_EN     = 3;
    localparam int unsigned RT_T1_EN     = 2;
    localparam int unsigned RT_T1_CLKSEL = 1;
    localparam int unsigned RT_IRQ1_EDGE = 0;

    // Routed pin positions
    localparam int unsigned PIN_PWM = 0;
    localparam int unsigned PIN_T0  = 5;
    localparam int unsigned PIN_CLK = 6;
    localparam int unsigned PIN_T1  = 0;

    // Interrupt status layout
    localparam int unsigned IRQ_W    = 3;
    localparam int unsigned IRQ_T0   = 0;
    localparam int unsigned IRQ_T1   = 1;
    localparam int unsigned IRQ_EXT1 = 2;

    // Edge select encodings and synchroniser depth
    localparam logic        EDGE_FALL   = 1'b0;
    localparam logic        EDGE_RISE   = 1'b1;
    localparam int unsigned SYNC_STAGES = 3;
    localparam logic [2:0]  SYNC_RST    = 3'h7;

endpackage

//--- verif/pur_pin_model.sv
// Purpose: Board side of port D and the interrupt 1 pin
// Assumes: Weak external pull-down on every port D pin
// Notes:   Pin command is taken one edge late, like a real input
`timescale 1ns/10ps
module pur_pin_model (
    input  wire logic       clk_i,
    input  wire logic       irq1_cmd_i,
    input  wire logic [7:0] pullup_i,
    input  wire logic [7:0] pushpull_i,
    input  wire logic [7:0] data_i,
    output logic            ext_irq1_pin_o,
    output logic [7:0]      level_o
);
    // Idle high so reset gives no edge
    initial ext_irq1_pin_o = 1'b1;
    always @(posedge clk_i) begin
        ext_irq1_pin_o <= irq1_cmd_i;
    end
    // Open drain releases high only through the pull-up
    assign level_o = (pushpull_i & data_i) |
                     (~pushpull_i & pullup_i);
endmodule

//--- verif/pur_top_asserts.sv
// Purpose: Port-level checks on the pull-up and routing block
// Assumes: One clock, synchronous active-high reset
// Notes:   Attached to every pur_top by the bind at the foot
`timescale 1ns/10ps
module pur_top_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic [31:0] dat_o,
    input wire logic [7:0]  porta_output_data_i,
    input wire logic [7:0]  portb_output_data_i,
    input wire logic [7:0]  portd_output_data_i,
    input wire logic [7:0]  porta_pushpull_select_i,
    input wire logic [7:0]  portb_pushpull_select_i,
    input wire logic [7:0]  portd_pushpull_select_i,
    input wire logic [7:0]  porta_alt_func_i,
    input wire logic [7:0]  portb_alt_func_i,
    input wire logic [7:0]  portd_alt_func_i,
    input wire logic [7:0]  porta_pullup_o,
    input wire logic [7:0]  portb_pullup_o,
    input wire logic [7:0]  portd_pullup_o,
    input wire logic        porta_pin0_sel_o,
    input wire logic        porta_pin0_out_o,
    input wire logic        porta_pin5_sel_o,
    input wire logic        porta_pin5_out_o,
    input wire logic        portd_pin6_sel_o,
    input wire logic        portd_pin6_out_o,
    input wire logic        portd_pin0_sel_o,
    input wire logic        portd_pin0_out_o,
    input wire logic        pwm_wave_i,
    input wire logic        timer0_ovf_i,
    input wire logic        timer1_ovf_i,
    input wire logic        timer1_clk_tick_o,
    input wire logic        ext_irq1_event_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_ack;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("late ack");
    property p_ack_pulse;
        ack_o |-> dat_o[31:8] == 24'h0 ##1 !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack");
    property p_pu_data;
        ((porta_pullup_o & ~$past(porta_output_data_i))
        | (portb_pullup_o & ~$past(portb_output_data_i))
        | (portd_pullup_o & ~$past(portd_output_data_i))) == 8'h00;
    endproperty
    a_pu_data: assert property (p_pu_data) else $error("pu data");
    property p_pu_pp;
        ((porta_pullup_o & $past(porta_pushpull_select_i))
        | (portb_pullup_o & $past(portb_pushpull_select_i))
        | (portd_pullup_o & $past(portd_pushpull_select_i))) == 8'h00;
    endproperty
    a_pu_pp: assert property (p_pu_pp) else $error("pu pushpull");
    property p_pu_alt;
        ((porta_pullup_o & $past(porta_alt_func_i))
        | (portb_pullup_o & $past(portb_alt_func_i))
        | (portd_pullup_o & $past(portd_alt_func_i))) == 8'h00;
    endproperty
    a_pu_alt: assert property (p_pu_alt) else $error("pu alt");
    property p_pwm;
        porta_pin0_sel_o [*2] |-> porta_pin0_out_o == $past(pwm_wave_i);
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm pin");
    property p_clk;
        portd_pin6_sel_o [*3] |-> portd_pin6_out_o != $past(portd_pin6_out_o);
    endproperty
    a_clk: assert property (p_clk) else $error("clock pin");
    property p_t0;
        porta_pin5_sel_o && $past(porta_pin5_sel_o) |->
            $changed(porta_pin5_out_o) == $past(timer0_ovf_i);
    endproperty
    a_t0: assert property (p_t0) else $error("t0 toggle");
    property p_t1;
        portd_pin0_sel_o && $past(portd_pin0_sel_o) |->
            $changed(portd_pin0_out_o) == $past(timer1_ovf_i);
    endproperty
    a_t1: assert property (p_t1) else $error("t1 toggle");
    property p_tog_rst;
        $fell(rst_i) |-> !porta_pin5_out_o && !portd_pin0_out_o;
    endproperty
    a_tog_rst: assert property (p_tog_rst) else $error("toggle rst");
    property p_tick;
        !timer1_clk_tick_o && !$past(rst_i) |=> timer1_clk_tick_o;
    endproperty
    a_tick: assert property (p_tick) else $error("tick gap");
    property p_evt;
        ext_irq1_event_o |=> !ext_irq1_event_o;
    endproperty
    a_evt: assert property (p_evt) else $error("irq1 event");
    c_evt: cover property (ext_irq1_event_o);
    c_clk: cover property (portd_pin6_sel_o [*3]);
    c_irq: cover property ($rose(irq_o));
endmodule

bind pur_top pur_top_asserts i_pur_top_asserts (
    .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .dat_o,
    .porta_output_data_i, .portb_output_data_i, .portd_output_data_i,
    .porta_pushpull_select_i, .portb_pushpull_select_i,
    .portd_pushpull_select_i, .porta_alt_func_i, .portb_alt_func_i,
    .portd_alt_func_i, .porta_pullup_o, .portb_pullup_o, .portd_pullup_o,
    .porta_pin0_sel_o, .porta_pin0_out_o, .porta_pin5_out_o,
    .porta_pin5_sel_o, .portd_pin0_sel_o,
    .portd_pin6_sel_o, .portd_pin6_out_o, .portd_pin0_out_o, .pwm_wave_i,
    .timer0_ovf_i, .timer1_ovf_i, .timer1_clk_tick_o, .ext_irq1_event_o,
    .irq_o
);

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the pull-up and routing block
// Assumes: Wishbone master at 40 MHz, no random stimulus
// Notes:   Expected values are worked out here from the pin rules
`timescale 1ns/10ps
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        we = 1'b0;
    logic        stb = 1'b0;
    logic [3:0]  sel = 4'hF;
    logic [7:0]  dat_v [3] = '{default: 8'hFF};
    logic [7:0]  pp_v [3] = '{default: 8'h00};
    logic [7:0]  alt_v [3] = '{default: 8'h00};
    logic [7:0]  pud_m [3];
    logic [7:0]  busy_m [3] = '{default: 8'h00};
    logic        pwm = 1'b0;
    logic        ovf0 = 1'b0;
    logic        ovf1 = 1'b0;
    logic        irq_cmd = 1'b1;
    logic        s;
    wire [7:0]   pu_w [3];
    wire [7:0]   ppo_w [3];
    wire [7:0]   lvl_d;
    wire [3:0]   sel_w;
    wire [3:0]   out_w;
    wire [31:0]  dat_o;
    wire [1:0]   div;
    wire         ack, pin, tick, evt, irq;
    int          fail_count = 0;
    int          total_checks = 0;

    initial forever #12.5 clk_i = ~clk_i;

    pur_top i_pur_top (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
        .dat_o(dat_o), .we_i(we), .sel_i(sel), .stb_i(stb), .cyc_i(stb),
        .ack_o(ack), .porta_output_data_i(dat_v[0]),
        .portb_output_data_i(dat_v[1]), .portd_output_data_i(dat_v[2]),
        .porta_pushpull_select_i(pp_v[0]), .portb_pushpull_select_i(pp_v[1]),
        .portd_pushpull_select_i(pp_v[2]), .porta_alt_func_i(alt_v[0]),
        .portb_alt_func_i(alt_v[1]), .portd_alt_func_i(alt_v[2]),
        .pwm_wave_i(pwm), .timer0_ovf_i(ovf0), .timer1_ovf_i(ovf1),
        .ext_irq1_pin_i(pin), .porta_pullup_o(pu_w[0]),
        .portb_pullup_o(pu_w[1]), .portd_pullup_o(pu_w[2]),
        .porta_pushpull_o(ppo_w[0]), .portb_pushpull_o(ppo_w[1]),
        .portd_pushpull_o(ppo_w[2]), .porta_pin0_sel_o(sel_w[0]),
        .porta_pin0_out_o(out_w[0]), .porta_pin5_sel_o(sel_w[1]),
        .porta_pin5_out_o(out_w[1]), .portd_pin6_sel_o(sel_w[2]),
        .portd_pin6_out_o(out_w[2]), .portd_pin0_sel_o(sel_w[3]),
        .portd_pin0_out_o(out_w[3]), .pwm_clock_divider_o(div),
        .timer1_clk_tick_o(tick), .ext_irq1_event_o(evt), .irq_o(irq)
    );

    pur_pin_model i_pur_pin_model (
        .clk_i(clk_i), .irq1_cmd_i(irq_cmd), .pullup_i(pu_w[2]),
        .pushpull_i(pp_v[2]), .data_i(dat_v[2]), .ext_irq1_pin_o(pin),
        .level_o(lvl_d)
    );

    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Request held until ack is sampled, then dropped for a cycle
    task automatic bus(input logic [5:0] idx, input logic w,
                       input logic [7:0] d);
        int n = 0;
        adr <= {idx, 2'b00};
        we <= w;
        wdat <= {24'h0, d};
        stb <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dat_o;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            fail_count++;
            stop_test();
        end
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] e,
                      input string nm);
        bus(idx, 1'b0, 8'h00);
        chk(nm, {24'h0, e}, rdat);
    endtask

    task automatic pins(input logic [7:0] d, input logic [7:0] p,
                        input logic [7:0] a);
        for (int i = 0; i < 3; i++) begin
            dat_v[i] <= d;
            pp_v[i] <= p;
            alt_v[i] <= a;
        end
        step(3);
    endtask

    task automatic chk_pu();
        for (int i = 0; i < 3; i++) begin
            chk("pullup", {24'h0, ~pud_m[i] & dat_v[i] & ~pp_v[i]
                & ~alt_v[i] & ~busy_m[i]}, {24'h0, pu_w[i]});
            chk("pushpull", {24'h0, pp_v[i]}, {24'h0, ppo_w[i]});
        end
    endtask

    task automatic pulse();
        ovf0 <= 1'b1;
        ovf1 <= 1'b1;
        step(1);
        ovf0 <= 1'b0;
        ovf1 <= 1'b0;
        step(2);
    endtask

    task automatic pin_edge(input logic lvl, input logic e);
        logic seen = 1'b0;
        irq_cmd <= lvl;
        repeat (12) begin
            @(posedge clk_i);
            if (evt === 1'b1) begin
                seen = 1'b1;
            end
        end
        chk("irq1 event", {31'h0, e}, {31'h0, seen});
    endtask

    initial begin
        pud_m = '{pur_pkg::RST_PA_PUD, pur_pkg::RST_PB_PUD,
                  pur_pkg::RST_PD_PUD};
        step(12);
        rst_i <= 1'b0;
        step(2);
        chk_pu();
        for (int i = 0; i < 4; i++) begin
            rd(pur_pkg::IDX_PA_PUD + 6'(i), 8'h00, "wo read");
        end
        bus(6'h0F, 1'b1, 8'hFF);
        rd(6'h0F, 8'h00, "unmapped");
        for (int i = 0; i < 3; i++) begin
            bus(pur_pkg::IDX_PA_PUD + 6'(i), 1'b1, 8'h00);
            pud_m[i] = 8'h00;
        end
        step(2);
        chk_pu();
        chk("pin level", 32'hFF, {24'h0, lvl_d});
        bus(pur_pkg::IDX_PD_PUD, 1'b1, 8'h0F);
        pud_m[2] = 8'h0F;
        pins(8'hF3, 8'h30, 8'h40);
        chk_pu();
        chk("pin level", 32'hB0, {24'h0, lvl_d});
        pins(8'hFF, 8'h00, 8'h00);
        bus(pur_pkg::IDX_ROUTE, 1'b1, 8'h9C);
        busy_m = '{8'h21, 8'h00, 8'h41};
        step(2);
        chk_pu();
        chk("pin select", 32'hF, {28'h0, sel_w});
        chk("divider", 32'h0, {30'h0, div});
        chk("toggles", 32'h0, {30'h0, out_w[1], out_w[3]});
        s = out_w[2];
        step(1);
        chk("clock pin", {31'h0, ~s}, {31'h0, out_w[2]});
        pwm <= 1'b1;
        step(2);
        chk("pwm pin", 32'h1, {31'h0, out_w[0]});
        pwm <= 1'b0;
        step(2);
        chk("pwm pin", 32'h0, {31'h0, out_w[0]});
        pulse();
        chk("toggles", 32'h3, {30'h0, out_w[1], out_w[3]});
        pulse();
        chk("toggles", 32'h0, {30'h0, out_w[1], out_w[3]});
        pulse();
        bus(pur_pkg::IDX_ROUTE, 1'b1, 8'h00);
        busy_m = '{default: 8'h00};
        pwm <= 1'b1;
        step(3);
        chk("pin select", 32'h0, {28'h0, sel_w});
        chk("idle pins", 32'h0, {30'h0, out_w[0], out_w[2]});
        chk_pu();
        pulse();
        bus(pur_pkg::IDX_ROUTE, 1'b1, 8'h0C);
        step(2);
        chk("toggles", 32'h3, {30'h0, out_w[1], out_w[3]});
        bus(pur_pkg::IDX_ROUTE, 1'b1, 8'h02);
        repeat (4) begin
            step(1);
            chk("tick", 32'h1, {31'h0, tick});
        end
        bus(pur_pkg::IDX_ROUTE, 1'b1, 8'h00);
        s = tick;
        step(1);
        chk("tick", {31'h0, ~s}, {31'h0, tick});
        rd(pur_pkg::IDX_IRQ_STS, 8'h03, "status");
        chk("masked irq", 32'h0, {31'h0, irq});
        bus(pur_pkg::IDX_IRQ_EN, 1'b1, 8'h03);
        chk("irq", 32'h1, {31'h0, irq});
        rd(pur_pkg::IDX_IRQ_EN, 8'h03, "enable");
        bus(pur_pkg::IDX_IRQ_CLR, 1'b1, 8'h03);
        chk("irq", 32'h0, {31'h0, irq});
        bus(pur_pkg::IDX_IRQ_EN, 1'b1, 8'h04);
        pin_edge(1'b0, 1'b1);
        chk("irq", 32'h1, {31'h0, irq});
        rd(pur_pkg::IDX_IRQ_STS, 8'h04, "status");
        bus(pur_pkg::IDX_IRQ_CLR, 1'b1, 8'h04);
        pin_edge(1'b1, 1'b0);
        bus(pur_pkg::IDX_ROUTE, 1'b1, 8'h01);
        pin_edge(1'b0, 1'b0);
        pin_edge(1'b1, 1'b1);
        stop_test();
    end
endmodule
